// file: common/otpsr_pkg.sv
// otpsr package: opcodes, otp map, status bit layout, reset values
// Function
// - otp space holds 1024 bytes, separate space
// - 32 regions of 32 bytes, each lockable
// - random number bytes 0..15 never programmable
// - lock bits live in bytes 010..013
// - lock bit zero refuses region programming
// - freeze bit blocks all otp programming
// - freeze stays set until reset
// - 05h reads status, 01h writes registers
// - 06h, 04h, 30h act on status bits
// - volatile bits take defaults on reset
// - nonvolatile and otp bits survive reset
// - write lock and low pin block register writes
// - write lock zero means no protection
// - program error flag, cleared by clear-status
// - erase error flag, cleared by clear-status
// - program error on locked region attempt
package otpsr_pkg;
    localparam logic [7:0] OP_WRITE_REGS = 8'h01;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_SET_WEL = 8'h06;
    localparam logic [7:0] OP_CLEAR_WEL = 8'h04;
    localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
    localparam logic [7:0] OP_OTP_PROGRAM = 8'h42;
    localparam logic [7:0] OP_OTP_READ = 8'h4B;
    localparam logic [7:0] OP_READ_CONFIG = 8'h35;
    localparam int OTP_BYTES = 1024;
    localparam int OTP_AW = 10;
    localparam int REGION_SHIFT = 5;
    localparam logic [9:0] RANDOM_LAST = 10'h00F;
    localparam logic [9:0] LOCK_FIRST = 10'h010;
    localparam logic [9:0] LOCK_LAST = 10'h013;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int SR_LOCK_BIT = 7;
    localparam int SR_PERR_BIT = 6;
    localparam int SR_EERR_BIT = 5;
    localparam int SR_BP_LSB = 2;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_WIP_BIT = 0;
    localparam int CR_FREEZE_BIT = 0;
    localparam logic [7:0] CR_RESET = 8'h00;
endpackage

// file: hw/otpsr_mem.sv
// otpsr otp array: one-write-port byte memory, registered read
`timescale 1ns/1ps
`default_nettype none
module otpsr_mem #(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    input wire logic i_clk_sys,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [7:0] o_rdata
);
    initial
    begin
        if (DEPTH != (1 << AW))
        begin
            $error("otpsr_mem depth must equal two to the address width");
        end
    end

    // cells start erased and are never reset: nonvolatile contents
    logic [7:0] mem [DEPTH] = '{default: 8'hFF};

    // programming can only clear bits, like real otp cells
    always_ff @(posedge i_clk_sys)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= mem[i_waddr] & i_wdata;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        o_rdata <= mem[i_raddr];
    end
endmodule
`default_nettype wire

// file: hw/otpsr_top.sv
// otpsr top: serial command decoder for otp space and status register
`timescale 1ns/1ps
`default_nettype none
module otpsr_top (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic i_wp_n,
    input wire logic i_prog_fail,
    input wire logic i_erase_fail,
    output logic o_miso,
    output logic o_miso_oe_n,
    output logic [7:0] o_status,
    output logic o_freeze
);
    // pins are asynchronous: two flops each, stage one read by stage two only
    logic [1:0] sck_s_q, cs_s_q, mosi_s_q, wp_s_q;
    logic sck_d1_q;
    always_ff @(posedge i_clk_sys)
    begin
        sck_s_q <= {sck_s_q[0], i_sck};
        cs_s_q <= {cs_s_q[0], i_cs_n};
        mosi_s_q <= {mosi_s_q[0], i_mosi};
        wp_s_q <= {wp_s_q[0], i_wp_n};
        sck_d1_q <= sck_s_q[1];
    end
    wire sck_rise = sck_s_q[1] & ~sck_d1_q;
    wire sck_fall = ~sck_s_q[1] & sck_d1_q;
    wire sel = ~cs_s_q[1];

    // frame shifting: bit counter and byte assembler
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [15:0] byte_cnt_q;
    logic [7:0] opcode_q;
    logic [23:0] addr_q;
    wire byte_done = sel & sck_rise & (bit_cnt_q == 3'h7);
    wire [7:0] rx_byte = {shift_q[6:0], mosi_s_q[1]};
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !sel)
        begin
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            byte_cnt_q <= 16'h0000;
        end
        else if (sck_rise)
        begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q <= rx_byte;
            if (bit_cnt_q == 3'h7)
            begin
                byte_cnt_q <= byte_cnt_q + 16'h0001;
            end
        end
    end

    // capture opcode and three address bytes; data bytes are used straight from rx_byte
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
        end
        else if (byte_done)
        begin
            if (byte_cnt_q == 16'h0000)
            begin
                opcode_q <= rx_byte;
            end
            else if (byte_cnt_q < 16'h0004)
            begin
                addr_q <= {addr_q[15:0], rx_byte};
            end
        end
    end

    // registers: lock and bp nonvolatile, errors and wel volatile
    // nonvolatile bits start at their shipped value and ignore reset
    logic lock_q = 1'b0;
    logic [2:0] bp_q = 3'h0;
    logic perr_q, eerr_q, wel_q, otp_ok_q;
    logic [7:0] cfg_q;
    logic freeze_q;
    logic [7:0] wrr_sr_q;
    logic wrr_pend_q;
    wire [7:0] status = {lock_q, perr_q, eerr_q, bp_q, wel_q, perr_q | eerr_q};
    wire reg_locked = lock_q & ~wp_s_q[1];
    logic sel_q;
    always_ff @(posedge i_clk_sys)
    begin
        sel_q <= i_rst ? 1'b0 : sel;
    end
    wire frame_end = sel_q & ~sel;

    // otp program request decoded per data byte
    wire is_otp_prog = (opcode_q == otpsr_pkg::OP_OTP_PROGRAM);
    wire data_byte = byte_done & (byte_cnt_q >= 16'h0004);
    logic [9:0] prog_addr_q;
    wire [9:0] prog_addr = addr_q[9:0] + prog_addr_q;
    wire [4:0] region = prog_addr[9:otpsr_pkg::REGION_SHIFT];
    logic [31:0] lock_bits_q = 32'hFFFFFFFF;
    wire in_space = (addr_q[23:10] == 14'h0000);
    wire prot_random = (prog_addr <= otpsr_pkg::RANDOM_LAST);
    wire region_locked = ~lock_bits_q[region];
    wire otp_refuse = freeze_q | prot_random | region_locked | ~in_space;
    wire otp_we = data_byte & is_otp_prog & wel_q & ~otp_refuse;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !sel)
        begin
            prog_addr_q <= 10'h000;
        end
        else if (data_byte)
        begin
            prog_addr_q <= prog_addr_q + 10'h001;
        end
    end

    // lock bit shadow of bytes 010..013, updated with the array
    always_ff @(posedge i_clk_sys)
    begin
        if (otp_we && prog_addr >= otpsr_pkg::LOCK_FIRST && prog_addr <= otpsr_pkg::LOCK_LAST)
        begin
            lock_bits_q[{prog_addr[1:0], 3'h0} +: 8] <=
                lock_bits_q[{prog_addr[1:0], 3'h0} +: 8] & rx_byte;
        end
    end

    // otp array instance; read address walks the otp read frame
    logic [7:0] otp_rdata;
    logic [9:0] rd_ptr_q;
    otpsr_mem #(
        .DEPTH(otpsr_pkg::OTP_BYTES),
        .AW(otpsr_pkg::OTP_AW)
    ) u_mem (
        .i_clk_sys(i_clk_sys),
        .i_we(otp_we),
        .i_waddr(prog_addr),
        .i_wdata(rx_byte),
        .i_raddr(rd_ptr_q),
        .o_rdata(otp_rdata)
    );

    // write-registers status byte latched on byte 1 and applied at frame end; config byte 2 applied as it completes
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            wrr_sr_q <= 8'h00;
            wrr_pend_q <= 1'b0;
        end
        else if (frame_end)
        begin
            wrr_pend_q <= 1'b0;
        end
        else if (byte_done && opcode_q == otpsr_pkg::OP_WRITE_REGS && byte_cnt_q == 16'h0001)
        begin
            wrr_sr_q <= rx_byte;
            wrr_pend_q <= wel_q & ~reg_locked;
        end
    end

    // nonvolatile status bits: untouched by reset
    always_ff @(posedge i_clk_sys)
    begin
        if (frame_end && wrr_pend_q)
        begin
            lock_q <= wrr_sr_q[otpsr_pkg::SR_LOCK_BIT];
            bp_q <= wrr_sr_q[otpsr_pkg::SR_BP_LSB +: 3];
        end
    end

    // configuration register; freeze only sets until reset
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            cfg_q <= otpsr_pkg::CR_RESET;
            freeze_q <= 1'b0;
        end
        else if (byte_done && opcode_q == otpsr_pkg::OP_WRITE_REGS &&
                 byte_cnt_q == 16'h0002 && wrr_pend_q)
        begin
            cfg_q <= rx_byte;
            freeze_q <= freeze_q | rx_byte[otpsr_pkg::CR_FREEZE_BIT];
        end
    end

    // write enable latch: set/clear opcodes, cleared after an accepted register write or an error-free program
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            wel_q <= 1'b0;
        end
        else if (frame_end)
        begin
            unique case (opcode_q)
                otpsr_pkg::OP_SET_WEL: wel_q <= 1'b1;
                otpsr_pkg::OP_CLEAR_WEL: wel_q <= 1'b0;
                otpsr_pkg::OP_WRITE_REGS: wel_q <= wel_q & ~wrr_pend_q;
                otpsr_pkg::OP_OTP_PROGRAM: wel_q <= wel_q & (perr_q | ~otp_ok_q);
                default: wel_q <= wel_q;
            endcase
        end
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !sel)
        begin
            otp_ok_q <= 1'b0;
        end
        else if (otp_we)
        begin
            otp_ok_q <= 1'b1;
        end
    end

    // error flags: a new error wins over a simultaneous clear
    wire prog_err = i_prog_fail | (data_byte & is_otp_prog & wel_q & otp_refuse);
    wire clr_status = frame_end & (opcode_q == otpsr_pkg::OP_CLEAR_STATUS);
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            perr_q <= 1'b0;
            eerr_q <= 1'b0;
        end
        else
        begin
            perr_q <= prog_err | (perr_q & ~clr_status);
            eerr_q <= i_erase_fail | (eerr_q & ~clr_status);
        end
    end

    // read path: status, config or otp bytes, shifted out on falling edges
    logic [7:0] tx_q;
    wire rd_otp = (opcode_q == otpsr_pkg::OP_OTP_READ);
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !sel)
        begin
            rd_ptr_q <= 10'h000;
        end
        else if (byte_done && byte_cnt_q == 16'h0003)
        begin
            rd_ptr_q <= {addr_q[1:0], rx_byte};
        end
        // the dummy byte must not advance the pointer, only data bytes do
        else if (byte_done && rd_otp && byte_cnt_q >= 16'h0005)
        begin
            rd_ptr_q <= rd_ptr_q + 10'h001;
        end
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !sel)
        begin
            tx_q <= 8'h00;
        end
        else if (sck_fall && bit_cnt_q == 3'h0 && byte_cnt_q != 16'h0000)
        begin
            unique case (opcode_q)
                otpsr_pkg::OP_READ_STATUS: tx_q <= status;
                otpsr_pkg::OP_READ_CONFIG: tx_q <= cfg_q;
                otpsr_pkg::OP_OTP_READ: tx_q <= (byte_cnt_q > 16'h0004) ? otp_rdata : 8'h00;
                default: tx_q <= 8'h00;
            endcase
        end
        else if (sck_fall)
        begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // outputs all registered
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_miso <= 1'b0;
            o_miso_oe_n <= 1'b1;
            o_status <= 8'h00;
            o_freeze <= 1'b0;
        end
        else
        begin
            o_miso <= tx_q[7];
            o_miso_oe_n <= ~sel;
            o_status <= status;
            o_freeze <= freeze_q;
        end
    end

    // otp writes never happen while frozen
    a_freeze_blocks: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        freeze_q |-> !otp_we) else $error("otp written while frozen");
    // random number bytes never written
    a_random_safe: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        otp_we |-> prog_addr > otpsr_pkg::RANDOM_LAST) else $error("random number written");
    // freeze cannot fall outside reset
    a_freeze_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        freeze_q |=> freeze_q) else $error("freeze dropped");
    // locked region refused with program error
    a_lock_error: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (data_byte && is_otp_prog && wel_q && region_locked) |=> perr_q)
        else $error("locked region attempt without error");
    // clear-status clears an idle error flag
    a_clear_err: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (clr_status && !prog_err) |=> !perr_q) else $error("error not cleared");
    a_clear_eerr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (clr_status && !i_erase_fail) |=> !eerr_q) else $error("erase err stuck");
    // locked register write leaves lock bit unchanged
    a_reg_lock: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_end && reg_locked && $past(reg_locked)) |=> $stable(lock_q))
        else $error("locked register changed");
    // set-write-enable frame raises the latch
    a_wel_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_end && opcode_q == otpsr_pkg::OP_SET_WEL) |=> wel_q)
        else $error("write enable not set");
endmodule
`default_nettype wire

// file: sim/otpsr_host.sv
// otpsr host model: serial controller that drives the command pins
`timescale 1ns/1ps
`default_nettype none
module otpsr_host (
    input wire logic i_clk_sys,
    input wire logic i_miso,
    input wire logic i_miso_oe_n,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_mosi
);
    // half of the 160 ns link period, in system cycles
    localparam int HALF = 16;

    // pins idle deselected, sck low between frames
    initial
    begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // wait n edges, then step just off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    // open a frame; the first bit follows half a period later
    task automatic start();
        tick(1);
        o_cs_n = 1'b0;
        tick(HALF);
    endtask

    // close a frame; released data line flips so a stale bit never looks valid
    task automatic stop();
        tick(HALF);
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        tick(HALF);
    endtask

    // one byte msb first; miso taken just before each rise, unknown if not driven
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            o_mosi = tx[i];
            tick(HALF);
            rx[i] = i_miso_oe_n ? 1'bx : i_miso;
            o_sck = 1'b1;
            tick(HALF);
            o_sck = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: sim/otpsr_top_bench.sv
// otpsr bench: command-level tests of otp space and status register
`timescale 1ns/1ps
`default_nettype none
module otpsr_top_bench;
    localparam int LIMIT = 80000;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic prog_fail = 1'b0;
    logic erase_fail = 1'b0;
    logic sck, cs_n, mosi, miso, miso_oe_n, freeze;
    logic [7:0] status, v0, v1;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    otpsr_top i_dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n),
        .i_mosi(mosi), .i_wp_n(wp_n), .i_prog_fail(prog_fail), .i_erase_fail(erase_fail),
        .o_miso(miso), .o_miso_oe_n(miso_oe_n), .o_status(status), .o_freeze(freeze));
    otpsr_host i_host (.i_clk_sys(clk_sys), .i_miso(miso), .i_miso_oe_n(miso_oe_n),
        .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));

    always #2.5 clk_sys = ~clk_sys;

    // hang guard: a stuck handshake ends the run as a mismatch
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            failures = failures + 1;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // single-byte command frame
    task automatic cmd(input logic [7:0] op);
        logic [7:0] rx;
        i_host.start();
        i_host.xfer(op, rx);
        i_host.stop();
    endtask

    // status through the read command and on the port, under a mask
    task automatic sts(input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] rx;
        logic [7:0] v;
        i_host.start();
        i_host.xfer(otpsr_pkg::OP_READ_STATUS, rx);
        i_host.xfer(8'h00, v);
        i_host.stop();
        check("status read", v & mask, exp);
        check("status port", status & mask, exp);
    endtask

    // configuration register through its read command
    task automatic cfg(input logic [7:0] exp);
        logic [7:0] rx;
        logic [7:0] v;
        i_host.start();
        i_host.xfer(otpsr_pkg::OP_READ_CONFIG, rx);
        i_host.xfer(8'h00, v);
        i_host.stop();
        check("config read", v, exp);
    endtask

    // write enable, then status and config bytes
    task automatic wr_regs(input logic [7:0] sr, input logic [7:0] cr);
        logic [7:0] rx;
        cmd(otpsr_pkg::OP_SET_WEL);
        i_host.start();
        i_host.xfer(otpsr_pkg::OP_WRITE_REGS, rx);
        i_host.xfer(sr, rx);
        i_host.xfer(cr, rx);
        i_host.stop();
    endtask

    // otp frame: opcode, 24-bit address, dummy on reads, one data byte
    task automatic otp(input logic [7:0] op, input logic [9:0] a, input logic [7:0] d,
        output logic [7:0] v);
        logic [7:0] rx;
        i_host.start();
        i_host.xfer(op, rx);
        i_host.xfer(8'h00, rx);
        i_host.xfer({6'h00, a[9:8]}, rx);
        i_host.xfer(a[7:0], rx);
        if (op == otpsr_pkg::OP_OTP_READ)
            i_host.xfer(8'h00, rx);
        i_host.xfer(d, v);
        i_host.stop();
    endtask

    task automatic prog(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] v;
        cmd(otpsr_pkg::OP_SET_WEL);
        otp(otpsr_pkg::OP_OTP_PROGRAM, a, d, v);
    endtask

    task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
        logic [7:0] v;
        otp(otpsr_pkg::OP_OTP_READ, a, 8'h00, v);
        check("otp byte", v, exp);
    endtask

    task automatic pulse_reset();
        rst = 1'b1;
        i_host.tick(2);
        rst = 1'b0;
        i_host.tick(4);
    endtask

    // main sequence
    initial
    begin
        pulse_reset();
        sts(8'hFF, 8'h00);
        check("freeze", {7'h00, freeze}, 8'h00);
        rdc(10'h010, 8'hFF);
        rdc(10'h013, 8'hFF);
        rdc(10'h014, 8'hFF);
        rdc(10'h3FF, 8'hFF);
        $display("test delivered state done");
        cmd(otpsr_pkg::OP_SET_WEL);
        sts(8'h02, 8'h02);
        cmd(otpsr_pkg::OP_CLEAR_WEL);
        sts(8'h02, 8'h00);
        otp(otpsr_pkg::OP_OTP_PROGRAM, 10'h020, 8'h00, v0);
        rdc(10'h020, 8'hFF);
        prog(10'h020, 8'hA5);
        rdc(10'h020, 8'hA5);
        otp(otpsr_pkg::OP_OTP_READ, 10'h005, 8'h00, v0);
        prog(10'h005, 8'h00);
        otp(otpsr_pkg::OP_OTP_READ, 10'h005, 8'h00, v1);
        check("random byte", v1, v0);
        sts(8'h40, 8'h40);
        cmd(otpsr_pkg::OP_CLEAR_STATUS);
        sts(8'h61, 8'h00);
        $display("test write enable and random done");
        // lock region 1 only: byte 010 bit 1
        prog(10'h010, 8'hFD);
        rdc(10'h010, 8'hFD);
        prog(10'h021, 8'h00);
        sts(8'h40, 8'h40);
        rdc(10'h021, 8'hFF);
        cmd(otpsr_pkg::OP_CLEAR_STATUS);
        prog(10'h040, 8'h00);
        rdc(10'h040, 8'h00);
        prog(10'h014, 8'h5A);
        rdc(10'h014, 8'h5A);
        $display("test region lock done");
        i_host.tick(1);
        prog_fail = 1'b1;
        i_host.tick(1);
        prog_fail = 1'b0;
        sts(8'h61, 8'h41);
        cmd(otpsr_pkg::OP_CLEAR_STATUS);
        erase_fail = 1'b1;
        i_host.tick(1);
        erase_fail = 1'b0;
        sts(8'h61, 8'h21);
        cmd(otpsr_pkg::OP_CLEAR_STATUS);
        sts(8'h61, 8'h00);
        $display("test error flags done");
        wr_regs(8'h9C, 8'h00);
        sts(8'hFC, 8'h9C);
        wp_n = 1'b0;
        wr_regs(8'h00, 8'h02);
        sts(8'hFC, 8'h9C);
        cfg(8'h00);
        wp_n = 1'b1;
        wr_regs(8'h00, 8'h00);
        sts(8'hFC, 8'h00);
        wp_n = 1'b0;
        wr_regs(8'h0C, 8'h02);
        sts(8'hFC, 8'h0C);
        cfg(8'h02);
        wp_n = 1'b1;
        $display("test register lock done");
        wr_regs(8'h0C, 8'h01);
        check("freeze", {7'h00, freeze}, 8'h01);
        cfg(8'h01);
        prog(10'h060, 8'h00);
        rdc(10'h060, 8'hFF);
        cmd(otpsr_pkg::OP_CLEAR_STATUS);
        prog(10'h011, 8'h00);
        rdc(10'h011, 8'hFF);
        cmd(otpsr_pkg::OP_CLEAR_STATUS);
        wr_regs(8'h0C, 8'h00);
        check("freeze", {7'h00, freeze}, 8'h01);
        pulse_reset();
        check("freeze", {7'h00, freeze}, 8'h00);
        sts(8'hFF, 8'h0C);
        cfg(8'h00);
        rdc(10'h020, 8'hA5);
        $display("test freeze and reset done");
        conclude();
    end
endmodule
`default_nettype wire
